// >>> design/tcv_top.sv
// timer channel value registers, capture/compare and pin function mux
`timescale 1ns/1ps
module tcv_top
   import tcv_pkg::*;
#(
   parameter int N = NUM_CHAN
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire tcv_avl_req_t avl_req,
   output logic [DATA_W-1:0] avl_readdata,
   output logic avl_waitrequest,
   input wire logic [VAL_W-1:0] free_counter_value,
   input wire logic [N-1:0] chan_pin_in,
   output logic [N-1:0] chan_pin_out,
   output logic [N-1:0] chan_pin_oe_n,
   input wire logic clk_pin_in,
   output logic clk_pin_out,
   output logic clk_pin_oe_n,
   output logic external_count_clock_pin,
   output logic [2:0] prescale_select,
   output logic [N-1:0] chan_event_flag,
   output logic irq
);
   // ------------------------------------------------------------------
   // bus slave: one wait state per access
   // ------------------------------------------------------------------
   logic wait_r;
   logic req;
   logic accept;
   logic [5:0] idx;
   logic [DATA_W-1:0] rd_nxt;
   assign req = avl_req.read | avl_req.write;
   assign accept = req & ~wait_r;
   assign idx = avl_req.address[ADDR_W-1:2];
   // waitrequest drops only for the cycle in which the access lands
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         wait_r <= 1'b1;
      else
         wait_r <= ~(req & wait_r);
   end
   assign avl_waitrequest = wait_r;
   // ------------------------------------------------------------------
   // shared registers
   // ------------------------------------------------------------------
   logic [VAL_W-1:0] value_r [N];
   tcv_ctrl_t ctrl_r [N];
   logic [2:0] prescale_r;
   logic [N-1:0] status_r;
   logic [N-1:0] mask_r;
   logic [N-1:0] event_pulse;
   logic [N-1:0] pin_s1_r;
   logic [N-1:0] pin_s2_r;
   logic [N-1:0] pin_prev_r;
   logic clk_s1_r;
   logic clk_s2_r;
   logic [VAL_W-1:0] cnt_prev_r;
   logic cnt_tick;
   logic [N/2-1:0] active_odd_r;
   logic [N/2-1:0] swap_pend_r;
   logic wr_acc;
   logic rd_acc;
   logic [N-1:0] match_v;
   assign wr_acc = accept & avl_req.write;
   assign rd_acc = accept & avl_req.read;
   // match only when the counter moves, so a held count fires once
   assign cnt_tick = free_counter_value != cnt_prev_r;
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         pin_prev_r <= '0;
         clk_s1_r <= 1'b0;
         clk_s2_r <= 1'b0;
         cnt_prev_r <= '0;
      end
      else
      begin
         pin_s1_r <= chan_pin_in;
         pin_s2_r <= pin_s1_r;
         pin_prev_r <= pin_s2_r;
         clk_s1_r <= clk_pin_in;
         clk_s2_r <= clk_s1_r;
         cnt_prev_r <= free_counter_value;
      end
   end
   // ------------------------------------------------------------------
   // per channel logic
   // ------------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < N; c++)
      begin : g_chan
         localparam logic [5:0] HI_IDX = IDX_VAL_BASE + 6'(2 * c);
         localparam logic [5:0] LO_IDX = IDX_VAL_BASE + 6'(2 * c + 1);
         localparam logic [5:0] CT_IDX = IDX_CTRL_BASE + 6'(c);
         localparam bit IS_ODD = (c % 2) == 1;
         localparam int PAIR = c / 2;
         logic odd_off;
         logic buf_mode;
         logic [1:0] els;
         logic cap_mode;
         logic cmp_mode;
         logic rise;
         logic fall;
         logic cap_edge;
         logic cap_lock_r;
         logic cmp_inhibit_r;
         logic oc_level_r;
         logic is_active;
         logic match;
         logic cmp_hit;
         logic wr_hi;
         logic wr_lo;
         assign wr_hi = wr_acc & (idx == HI_IDX) & avl_req.byteenable[0];
         assign wr_lo = wr_acc & (idx == LO_IDX) & avl_req.byteenable[0];
         if (IS_ODD)
         begin : g_odd
            assign odd_off = ctrl_r[c-1].buffered_mode_select;
            assign buf_mode = 1'b0;
            assign is_active = active_odd_r[PAIR];
         end
         else
         begin : g_even
            assign odd_off = 1'b0;
            assign buf_mode = ctrl_r[c].buffered_mode_select;
            assign is_active = ~(buf_mode & active_odd_r[PAIR]);
         end
         assign els = {ctrl_r[c].edge_level_select_hi, ctrl_r[c].edge_level_select_lo};
         assign cap_mode = ~odd_off & ~buf_mode & ~ctrl_r[c].capture_or_compare_select
            & (els != ELS_NONE);
         // odd channel has no compare mode of its own while its even partner is buffered
         assign cmp_mode = IS_ODD ? (odd_off ? 1'b0
            : ctrl_r[c].capture_or_compare_select & (els != ELS_NONE))
            : (buf_mode | ctrl_r[c].capture_or_compare_select) & (els != ELS_NONE);
         assign rise = pin_s2_r[c] & ~pin_prev_r[c];
         assign fall = ~pin_s2_r[c] & pin_prev_r[c];
         always_comb
         begin
            unique case (els)
               ELS_RISE_TOGGLE: cap_edge = rise;
               ELS_FALL_CLEAR: cap_edge = fall;
               ELS_BOTH_SET: cap_edge = rise | fall;
               default: cap_edge = 1'b0;
            endcase
         end
         // buffered pair: only the active register may match
         if (IS_ODD)
         begin : g_mo
            logic pair_els_on;
            assign pair_els_on = {ctrl_r[c-1].edge_level_select_hi,
               ctrl_r[c-1].edge_level_select_lo} != ELS_NONE;
            // partner register of a buffered pair follows the even settings
            assign cmp_hit = cmp_mode | (odd_off & pair_els_on & is_active);
         end
         else
         begin : g_me
            assign cmp_hit = cmp_mode & is_active;
         end
         assign match = cmp_hit & cnt_tick & ~cmp_inhibit_r
            & (free_counter_value == value_r[c]);
         assign event_pulse[c] = (cap_mode & cap_edge & ~cap_lock_r) | match;
         assign match_v[c] = match;
         // value storage: no reset on purpose
         always_ff @(posedge clk)
         begin
            if (wr_hi)
               value_r[c][VAL_W-1:BYTE_W] <= avl_req.writedata[BYTE_W-1:0];
            else if (cap_mode & cap_edge & ~cap_lock_r)
               value_r[c][VAL_W-1:BYTE_W] <= free_counter_value[VAL_W-1:BYTE_W];
            if (wr_lo)
               value_r[c][BYTE_W-1:0] <= avl_req.writedata[BYTE_W-1:0];
            else if (cap_mode & cap_edge & ~cap_lock_r)
               value_r[c][BYTE_W-1:0] <= free_counter_value[BYTE_W-1:0];
         end
         always_ff @(posedge clk)
         begin
            if (!reset_n)
               ctrl_r[c] <= CTRL_RESET;
            else if (wr_acc & (idx == CT_IDX) & avl_req.byteenable[0])
               ctrl_r[c] <= tcv_ctrl_t'(avl_req.writedata[CTRL_W-1:0]);
         end
         // capture lock between high and low byte reads
         always_ff @(posedge clk)
         begin
            if (!reset_n | ~cap_mode)
               cap_lock_r <= 1'b0;
            else if (rd_acc & (idx == LO_IDX))
               cap_lock_r <= 1'b0;
            else if (rd_acc & (idx == HI_IDX))
               cap_lock_r <= 1'b1;
         end
         // compare inhibit between high and low byte writes
         always_ff @(posedge clk)
         begin
            if (!reset_n)
               cmp_inhibit_r <= 1'b0;
            else if (wr_lo)
               cmp_inhibit_r <= 1'b0;
            else if (wr_hi)
               cmp_inhibit_r <= 1'b1;
         end
         // compare output level and pin drive
         always_ff @(posedge clk)
         begin
            if (!reset_n)
            begin
               oc_level_r <= 1'b0;
               chan_pin_out[c] <= 1'b0;
               chan_pin_oe_n[c] <= 1'b1;
            end
            else
            begin
               // even pin carries the matches of both halves of a buffered pair
               if (!IS_ODD && (match || (buf_mode && match_v[(c + 1) % N])))
               begin
                  unique case (els)
                     ELS_RISE_TOGGLE: oc_level_r <= ~oc_level_r;
                     ELS_FALL_CLEAR: oc_level_r <= 1'b0;
                     ELS_BOTH_SET: oc_level_r <= 1'b1;
                     default: oc_level_r <= oc_level_r;
                  endcase
               end
               else if (IS_ODD && match && !odd_off)
               begin
                  unique case (els)
                     ELS_RISE_TOGGLE: oc_level_r <= ~oc_level_r;
                     ELS_FALL_CLEAR: oc_level_r <= 1'b0;
                     ELS_BOTH_SET: oc_level_r <= 1'b1;
                     default: oc_level_r <= oc_level_r;
                  endcase
               end
               if (odd_off || els == ELS_NONE)
               begin
                  chan_pin_oe_n[c] <= ~ctrl_r[c].pin_direction_bit;
                  chan_pin_out[c] <= ctrl_r[c].port_data;
               end
               else if (cap_mode)
               begin
                  chan_pin_oe_n[c] <= 1'b1;
                  chan_pin_out[c] <= 1'b0;
               end
               else
               begin
                  chan_pin_oe_n[c] <= 1'b0;
                  chan_pin_out[c] <= oc_level_r;
               end
            end
         end
      end
   endgenerate
   // ------------------------------------------------------------------
   // buffered pair: swap active register at the next pair event after an inactive low byte write
   // ------------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < N / 2; p++)
      begin : g_pair
         logic inact_lo_wr;
         assign inact_lo_wr = wr_acc & avl_req.byteenable[0]
            & (idx == IDX_VAL_BASE + 6'(active_odd_r[p] ? 4 * p + 1 : 4 * p + 3));
         always_ff @(posedge clk)
         begin
            if (!reset_n | ~ctrl_r[2*p].buffered_mode_select)
            begin
               active_odd_r[p] <= 1'b0;
               swap_pend_r[p] <= 1'b0;
            end
            else if (event_pulse[2*p] | event_pulse[2*p+1])
            begin
               active_odd_r[p] <= active_odd_r[p] ^ (swap_pend_r[p] | inact_lo_wr);
               swap_pend_r[p] <= 1'b0;
            end
            else if (inact_lo_wr)
               swap_pend_r[p] <= 1'b1;
         end
      end
   endgenerate
   // ------------------------------------------------------------------
   // global config, sticky flags, interrupt, clock pin
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         prescale_r <= '0;
         mask_r <= '0;
      end
      else if (wr_acc & avl_req.byteenable[0])
      begin
         if (idx == IDX_PRESCALE)
            prescale_r <= avl_req.writedata[2:0];
         if (idx == IDX_MASK)
            mask_r <= avl_req.writedata[N-1:0];
      end
   end
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         status_r <= '0;
      else if (wr_acc & avl_req.byteenable[0] & (idx == IDX_STATUS))
         status_r <= (status_r & ~avl_req.writedata[N-1:0]) | event_pulse;
      else
         status_r <= status_r | event_pulse;
   end
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         irq <= 1'b0;
         chan_event_flag <= '0;
         prescale_select <= '0;
         clk_pin_out <= 1'b0;
         clk_pin_oe_n <= 1'b1;
         external_count_clock_pin <= 1'b0;
      end
      else
      begin
         irq <= |(status_r & mask_r);
         chan_event_flag <= status_r;
         prescale_select <= prescale_r;
         if (prescale_r == PRESCALE_EXT_CLK)
         begin
            clk_pin_oe_n <= 1'b1;
            clk_pin_out <= 1'b0;
            external_count_clock_pin <= clk_s2_r;
         end
         else
         begin
            clk_pin_oe_n <= ~ctrl_r[N-1].pin_direction_bit;
            clk_pin_out <= ctrl_r[N-1].port_data;
            external_count_clock_pin <= 1'b0;
         end
      end
   end
   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------
   always_comb
   begin
      rd_nxt = '0;
      for (int i = 0; i < N; i++)
      begin
         if (idx == IDX_VAL_BASE + 6'(2 * i))
            rd_nxt[BYTE_W-1:0] = value_r[i][VAL_W-1:BYTE_W];
         if (idx == IDX_VAL_BASE + 6'(2 * i + 1))
            rd_nxt[BYTE_W-1:0] = value_r[i][BYTE_W-1:0];
         if (idx == IDX_CTRL_BASE + 6'(i))
            rd_nxt[CTRL_W-1:0] = ctrl_r[i];
      end
      if (idx == IDX_PRESCALE)
         rd_nxt[2:0] = prescale_r;
      if (idx == IDX_STATUS)
         rd_nxt[N-1:0] = status_r;
      if (idx == IDX_MASK)
         rd_nxt[N-1:0] = mask_r;
      if (idx == IDX_PINS)
         rd_nxt[N:0] = {clk_s2_r, pin_s2_r};
   end
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         avl_readdata <= '0;
      else if (req & wait_r & avl_req.read)
         avl_readdata <= rd_nxt;
   end
endmodule

// >>> shared/tcv_pkg.sv
// package for the timer channel value registers and pin multiplexer
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package tcv_pkg;
   localparam int NUM_CHAN = 4;
   localparam int VAL_W = 16;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // ------------------------------------------------------------------
   // register word indices (byte address = 4 * index)
   // ------------------------------------------------------------------
   localparam logic [5:0] IDX_VAL_BASE = 6'h00;
   localparam logic [5:0] IDX_CTRL_BASE = 6'h08;
   localparam logic [5:0] IDX_PRESCALE = 6'h0c;
   localparam logic [5:0] IDX_STATUS = 6'h0d;
   localparam logic [5:0] IDX_MASK = 6'h0e;
   localparam logic [5:0] IDX_PINS = 6'h0f;
   // ------------------------------------------------------------------
   // field encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] ELS_NONE = 2'h0;
   localparam logic [1:0] ELS_RISE_TOGGLE = 2'h1;
   localparam logic [1:0] ELS_FALL_CLEAR = 2'h2;
   localparam logic [1:0] ELS_BOTH_SET = 2'h3;
   localparam logic [2:0] PRESCALE_EXT_CLK = 3'h7;
   localparam int CTRL_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
   typedef struct packed {
      logic buffered_mode_select;
      logic capture_or_compare_select;
      logic edge_level_select_hi;
      logic edge_level_select_lo;
      logic pin_direction_bit;
      logic port_data;
   } tcv_ctrl_t;
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [DATA_W-1:0] writedata;
      logic [3:0] byteenable;
   } tcv_avl_req_t;
endpackage

// >>> verification/tcv_pin_model.sv
// pin-side sources resolving against the block's drivers
`timescale 1ns/1ps
module tcv_pin_model
   import tcv_pkg::*;
(
   input wire logic [NUM_CHAN-1:0] drv,
   input wire logic clk_drv,
   input wire logic [NUM_CHAN-1:0] chan_pin_out,
   input wire logic [NUM_CHAN-1:0] chan_pin_oe_n,
   input wire logic clk_pin_out,
   input wire logic clk_pin_oe_n,
   output logic [NUM_CHAN-1:0] chan_pin_in,
   output logic clk_pin_in
);
   // block wins the wire while it drives
   always_comb
   begin
      for (int i = 0; i < NUM_CHAN; i++)
         chan_pin_in[i] = chan_pin_oe_n[i] ? drv[i] : chan_pin_out[i];
      clk_pin_in = clk_pin_oe_n ? clk_drv : clk_pin_out;
   end
endmodule

// >>> verification/tcv_chk.sv
// port checker for the timer channel block
`timescale 1ns/1ps
module tcv_chk
   import tcv_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire tcv_avl_req_t avl_req,
   input wire logic [DATA_W-1:0] avl_readdata,
   input wire logic avl_waitrequest,
   input wire logic [NUM_CHAN-1:0] chan_pin_oe_n,
   input wire logic clk_pin_oe_n,
   input wire logic external_count_clock_pin,
   input wire logic [2:0] prescale_select,
   input wire logic [NUM_CHAN-1:0] chan_event_flag,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence req_s;
      (avl_req.read || avl_req.write) && avl_waitrequest;
   endsequence
   sequence ack_s;
      !avl_waitrequest;
   endsequence
   wait_one_a: assert property (req_s |=> ack_s)
      else $error("bus answer late");
   ack_pulse_a: assert property (req_s ##1 ack_s |=> avl_waitrequest)
      else $error("bus answer too long");
   read_upper_a: assert property (ack_s |-> avl_readdata[DATA_W-1:BYTE_W] == '0)
      else $error("read data upper bits set");
   extclk_off_a: assert property (
      (prescale_select != PRESCALE_EXT_CLK) [*2] |-> !external_count_clock_pin)
      else $error("count clock without select");
   clkpin_in_a: assert property (
      (prescale_select == PRESCALE_EXT_CLK) [*2] |-> clk_pin_oe_n)
      else $error("clock pin driven");
   presc_write_a: assert property ($changed(prescale_select) |->
      $past(avl_req.write) || $past(avl_req.write, 2))
      else $error("prescale changed unasked");
   irq_flag_a: assert property (irq |-> |chan_event_flag)
      else $error("irq without flag");
   flag_clear_a: assert property (
      |($past(chan_event_flag) & ~chan_event_flag) |->
      $past(avl_req.write) || $past(avl_req.write, 2) || $past(avl_req.write, 3))
      else $error("flag lost");
   oe_reset_a: assert property ($rose(reset_n) |-> (&chan_pin_oe_n) && clk_pin_oe_n)
      else $error("pin driven after reset");
endmodule
bind tcv_top tcv_chk chk (.clk(clk), .reset_n(reset_n), .avl_req(avl_req),
   .avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest),
   .chan_pin_oe_n(chan_pin_oe_n), .clk_pin_oe_n(clk_pin_oe_n),
   .external_count_clock_pin(external_count_clock_pin),
   .prescale_select(prescale_select), .chan_event_flag(chan_event_flag), .irq(irq));

// >>> verification/testbench.sv
// self-checking bench for the timer channel block
`timescale 1ns/1ps
module testbench;
   import tcv_pkg::*;
   logic clk, reset_n, wreq, ckin, ckout, ckoe_n, ext_clk, irq, clk_drv;
   tcv_avl_req_t avl_req;
   logic [DATA_W-1:0] rdata;
   logic [VAL_W-1:0] cnt;
   logic [NUM_CHAN-1:0] pin_in, pin_out, pin_oe_n, flag, drv;
   logic [2:0] psel;
   logic [7:0] q;
   int num_errors = 0;
   int cmp_count = 0;
   int seed = 38;
   int val_m[NUM_CHAN];
   int c[4];
   int v;
   tcv_top dut (.clk(clk), .reset_n(reset_n), .avl_req(avl_req), .avl_readdata(rdata),
      .avl_waitrequest(wreq), .free_counter_value(cnt), .chan_pin_in(pin_in),
      .chan_pin_out(pin_out), .chan_pin_oe_n(pin_oe_n), .clk_pin_in(ckin),
      .clk_pin_out(ckout), .clk_pin_oe_n(ckoe_n), .external_count_clock_pin(ext_clk),
      .prescale_select(psel), .chan_event_flag(flag), .irq(irq));
   tcv_pin_model pins (.drv(drv), .clk_drv(clk_drv), .chan_pin_out(pin_out),
      .chan_pin_oe_n(pin_oe_n), .clk_pin_out(ckout), .clk_pin_oe_n(ckoe_n),
      .chan_pin_in(pin_in), .clk_pin_in(ckin));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk8(input int e, input logic [7:0] g);
      cmp_count++;
      if (g !== e[7:0])
      begin
         num_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e[7:0], g);
      end
   endtask
   task automatic chk1(input logic e, input logic g);
      cmp_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int i;
      avl_req <= '{address: a, read: !wr, write: wr, writedata: {24'h0, d},
         byteenable: 4'hf};
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (wreq !== 1'b0 && i < 20);
      if (wreq !== 1'b0)
      begin
         num_errors++;
         give_verdict();
      end
      q = rdata[7:0];
      avl_req.read <= 1'b0;
      avl_req.write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input int d);
      bus(1'b1, a, d[7:0]);
   endtask
   task automatic rd(input logic [7:0] a, input int e);
      bus(1'b0, a, 8'h00);
      chk8(e, q);
   endtask
   task automatic edg(input int n, input logic lv, input int cv);
      cnt <= 16'(cv);
      drv[n] <= lv;
      cyc(8);
   endtask
   task automatic sweep(input int m);
      for (int k = -2; k < 3; k++)
      begin
         cnt <= 16'(m + k);
         @(posedge clk);
      end
      cyc(6);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      reset_n = 1'b0;
      avl_req = '0;
      cnt = '0;
      drv = '0;
      clk_drv = 1'b0;
      cyc(5);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(8'h20, 0);
      rd(8'h30, 0);
      chk8(15, 8'(pin_oe_n));
      $display("test reset done");
      for (int e = 1; e < 4; e++)
      begin
         wr(8'h20, e << 2);
         c[0] = $random(seed) & 32'hffff;
         c[1] = $random(seed) & 32'hffff;
         edg(0, 1'b1, c[0]);
         edg(0, 1'b0, c[1]);
         val_m[0] = (e == 1) ? c[0] : c[1];
         rd(8'h00, val_m[0] >> 8);
         rd(8'h04, val_m[0]);
         rd(8'h34, 1);
         chk8(1, 8'(flag));
         wr(8'h34, 1);
      end
      wr(8'h38, 1);
      for (int k = 0; k < 4; k++)
         c[k] = $random(seed) & 32'hffff;
      edg(0, 1'b1, c[0]);
      edg(0, 1'b0, c[1]);
      rd(8'h00, c[1] >> 8);
      edg(0, 1'b1, c[2]);
      rd(8'h04, c[1]);
      edg(0, 1'b0, c[3]);
      rd(8'h00, c[3] >> 8);
      rd(8'h04, c[3]);
      chk1(1'b1, irq);
      wr(8'h38, 0);
      cyc(2);
      chk1(1'b0, irq);
      wr(8'h34, 1);
      $display("test capture done");
      // channel 0 still captures, the rest are plain storage
      for (int n = 0; n < NUM_CHAN; n++)
      begin
         val_m[n] = $random(seed) & 32'hffff;
         wr(8'(8 * n), val_m[n] >> 8);
         wr(8'(8 * n + 4), val_m[n]);
      end
      for (int n = 0; n < NUM_CHAN; n++)
      begin
         rd(8'(8 * n), val_m[n] >> 8);
         rd(8'(8 * n + 4), val_m[n]);
      end
      wr(8'h40, 8'h5a);
      rd(8'h40, 0);
      $display("test storage done");
      v = $random(seed) & 32'hffff;
      wr(8'h08, v >> 8);
      wr(8'h0c, v);
      for (int l = 1; l < 4; l++)
      begin
         wr(8'h24, 8'h10 | (l << 2));
         sweep(v);
         chk1(l != 2, pin_out[1]);
         chk1(1'b0, pin_oe_n[1]);
         rd(8'h34, 2);
         wr(8'h34, 2);
      end
      wr(8'h08, v >> 8);
      sweep(v);
      rd(8'h34, 0);
      wr(8'h0c, v);
      sweep(v);
      rd(8'h34, 2);
      wr(8'h34, 2);
      wr(8'h20, 8'h34);
      wr(8'h08, 8'h00);
      sweep(val_m[0]);
      rd(8'h34, 1);
      chk1(1'b1, pin_oe_n[1]);
      // low write to the inactive half swaps the pair at the next match
      wr(8'h0c, v);
      sweep(val_m[0]);
      sweep(v & 32'hff);
      rd(8'h34, 3);
      chk1(1'b1, pin_out[0]);
      chk1(1'b0, pin_oe_n[0]);
      wr(8'h24, 8'h1f);
      cyc(2);
      chk1(1'b0, pin_oe_n[1]);
      chk1(1'b1, pin_out[1]);
      $display("test compare done");
      wr(8'h28, 8'h03);
      cyc(2);
      chk1(1'b0, pin_oe_n[2]);
      chk1(1'b1, pin_out[2]);
      wr(8'h28, 8'h0e);
      cyc(2);
      chk1(1'b1, pin_oe_n[2]);
      wr(8'h28, 8'h00);
      drv[2] <= 1'b1;
      cyc(5);
      bus(1'b0, 8'h3c, 8'h00);
      chk1(1'b1, q[2]);
      wr(8'h2c, 8'h03);
      wr(8'h30, 7);
      clk_drv <= 1'b1;
      cyc(5);
      chk1(1'b1, ext_clk);
      chk1(1'b1, ckoe_n);
      chk8(7, 8'(psel));
      wr(8'h30, 3);
      cyc(2);
      chk1(1'b0, ext_clk);
      chk1(1'b0, ckoe_n);
      chk1(1'b1, ckout);
      $display("test pin mux done");
      give_verdict();
   end
endmodule
